//--- logic/rmc_pkg.sv
// register map, field positions and reset values of the ring mac control port
package rmc_pkg;
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_OPTION = 8'h01;
  localparam logic [7:0] ADR_FUNC = 8'h02;
  localparam logic [7:0] ADR_INTR = 8'h03;
  localparam logic [7:0] ADR_INTR_MASK = 8'h04;
  localparam logic [7:0] ADR_EXC = 8'h05;
  localparam logic [7:0] ADR_PROTO_EVT = 8'h08;
  localparam logic [7:0] ADR_PROTO_MASK = 8'h09;
  localparam logic [7:0] ADR_CNT_EVT = 8'h0a;
  localparam logic [7:0] ADR_CNT_MASK = 8'h0b;
  localparam logic [7:0] ADR_ERR_EVT = 8'h0c;
  localparam logic [7:0] ADR_ERR_MASK = 8'h0d;
  localparam logic [7:0] ADR_STAT_CUR = 8'h10;
  localparam logic [7:0] ADR_CNT_BASE = 8'h11;
  localparam logic [7:0] ADR_PARAM_BASE = 8'h18;
  localparam logic [7:0] ADR_SHARED_LO = 8'h10;
  localparam logic [7:0] ADR_SHARED_HI = 8'h1f;
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_LOOP_LSB = 1;
  localparam int MODE_LOOP_W = 2;
  localparam int FN_SMR = 0;
  localparam int FN_MACRST = 1;
  localparam int FN_CLAIM = 2;
  localparam int FN_BEACON = 3;
  localparam int NUM_FN = 4;
  localparam int CLS_PROTO = 0;
  localparam int CLS_CNT = 1;
  localparam int CLS_ERR = 2;
  localparam int NUM_CLS = 3;
  localparam int ERR_REJECT_BIT = 0;
  localparam int NUM_CNT = 2;
  localparam int NUM_PARAM = 8;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PARAM_RST = 8'h00;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_OK = 2'b01,
    ACC_REJ = 2'b10
  } rmc_acc_e;
endpackage : rmc_pkg

//--- logic/rmc_sync.sv
// two-stage synchroniser for signals arriving from the ring engine side
`timescale 1ns/10ps
module rmc_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // only the second stage is ever looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : rmc_sync

//--- logic/rmc_evt_class.sv
// one event class: sticky condition latch, write-one-to-clear, per-event mask
`timescale 1ns/10ps
module rmc_evt_class #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic mask_wr,
  input wire logic [W-1:0] mask_wdata,
  output logic [W-1:0] latch,
  output logic [W-1:0] mask,
  output logic pend
);
  logic [W-1:0] latch_ff;
  logic [W-1:0] mask_ff;

  // a new event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= '0;
    end else begin
      latch_ff <= (latch_ff & ~clr) | set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= '0;
    end else if (mask_wr) begin
      mask_ff <= mask_wdata;
    end
  end

  assign latch = latch_ff;
  assign mask = mask_ff;
  assign pend = |(latch_ff & mask_ff);
endmodule : rmc_evt_class

//--- logic/rmc_ctrl_port.sv
// control port, event latching and two-level interrupt masking of the ring mac
`timescale 1ns/10ps
module rmc_ctrl_port #(
  parameter int NUM_PROTO = 8,
  parameter int NUM_ERR = 3,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] adr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [NUM_PROTO-1:0] proto_evt_in,
  input wire logic [NUM_ERR-1:0] err_in,
  input wire logic [rmc_pkg::NUM_CNT-1:0] cnt_inc_in,
  input wire logic [rmc_pkg::NUM_FN-1:0] fn_done_in,
  input wire logic [7:0] status_in,
  output logic irq,
  output logic mode_run,
  output logic [rmc_pkg::MODE_LOOP_W-1:0] mode_loop,
  output logic [7:0] option,
  output logic [rmc_pkg::NUM_FN-1:0] fn_start,
  output logic [8*rmc_pkg::NUM_PARAM-1:0] param
);
  localparam int NCE = 2 * rmc_pkg::NUM_CNT;
  localparam int NEE = 1 + NUM_ERR;
  localparam int EDGE_W = NUM_PROTO + NUM_ERR + rmc_pkg::NUM_CNT + rmc_pkg::NUM_FN;
  localparam int SYNC_W = EDGE_W + 8;

  function automatic logic is_shared(input logic [7:0] a);
    is_shared = (a >= rmc_pkg::ADR_SHARED_LO) && (a <= rmc_pkg::ADR_SHARED_HI);
  endfunction : is_shared

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic [7:0] mode_ff;
  logic [7:0] option_ff;
  logic [7:0] intr_mask_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic [rmc_pkg::NUM_FN-1:0] fn_start_ff;
  logic [rmc_pkg::NUM_FN-1:0] fn_busy_ff;
  logic [8*rmc_pkg::NUM_PARAM-1:0] param_ff;
  logic [CNT_W-1:0] cnt_ff [rmc_pkg::NUM_CNT];
  logic [EDGE_W-1:0] edge_prev_ff;
  rmc_pkg::rmc_acc_e acc_state_ff;
  rmc_pkg::rmc_acc_e nxt_acc_state;
  logic [7:0] nxt_rdata;

  logic [SYNC_W-1:0] sync_q;
  logic [EDGE_W-1:0] edge_lvl;
  logic [EDGE_W-1:0] edge_rise;
  logic [NUM_PROTO-1:0] proto_rise;
  logic [NUM_ERR-1:0] err_rise;
  logic [rmc_pkg::NUM_CNT-1:0] inc_rise;
  logic [rmc_pkg::NUM_FN-1:0] done_rise;
  logic [7:0] status_sync;
  logic access;
  logic reject;
  logic wr_ok;
  logic [rmc_pkg::NUM_CNT-1:0] ovf_hit;

  logic [NUM_PROTO-1:0] proto_latch;
  logic [NUM_PROTO-1:0] proto_mask;
  logic [NCE-1:0] cnt_latch;
  logic [NCE-1:0] cnt_mask;
  logic [NEE-1:0] err_latch;
  logic [NEE-1:0] err_mask;
  logic [rmc_pkg::NUM_CLS-1:0] cls_pend;

  // ring engine side runs on its own byte clock, so everything is resampled
  rmc_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({status_in, fn_done_in, cnt_inc_in, err_in, proto_evt_in}),
    .q(sync_q)
  );

  assign edge_lvl = sync_q[EDGE_W-1:0];
  assign status_sync = sync_q[SYNC_W-1:EDGE_W];

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_prev_ff <= '0;
    end else begin
      edge_prev_ff <= edge_lvl;
    end
  end

  // events are taken on the rising edge of a held level
  assign edge_rise = edge_lvl & ~edge_prev_ff;
  assign proto_rise = edge_rise[NUM_PROTO-1:0];
  assign err_rise = edge_rise[NUM_PROTO+NUM_ERR-1:NUM_PROTO];
  assign inc_rise = edge_rise[NUM_PROTO+NUM_ERR+rmc_pkg::NUM_CNT-1:NUM_PROTO+NUM_ERR];
  assign done_rise = edge_rise[EDGE_W-1:NUM_PROTO+NUM_ERR+rmc_pkg::NUM_CNT];

  // access checking against the current mode
  assign access = wr | rd;
  assign reject = access && is_shared(adr) && mode_ff[rmc_pkg::MODE_RUN_BIT];
  assign wr_ok = wr && !reject;

  always_comb begin
    nxt_acc_state = acc_state_ff;
    case (acc_state_ff)
      rmc_pkg::ACC_IDLE,
      rmc_pkg::ACC_OK,
      rmc_pkg::ACC_REJ: begin
        // reading the exception register must not overwrite its own answer
        if (access && !hit(adr, rmc_pkg::ADR_EXC)) begin
          nxt_acc_state = reject ? rmc_pkg::ACC_REJ : rmc_pkg::ACC_OK;
        end
      end
      default: begin
        nxt_acc_state = rmc_pkg::ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_state_ff <= rmc_pkg::ACC_IDLE;
    end else begin
      acc_state_ff <= nxt_acc_state;
    end
  end

  // operation registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= rmc_pkg::MODE_RST;
    end else if (wr && hit(adr, rmc_pkg::ADR_MODE)) begin
      mode_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      option_ff <= rmc_pkg::OPTION_RST;
    end else if (wr && hit(adr, rmc_pkg::ADR_OPTION)) begin
      option_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intr_mask_ff <= rmc_pkg::MASK_RST;
    end else if (wr && hit(adr, rmc_pkg::ADR_INTR_MASK)) begin
      intr_mask_ff <= wdata;
    end
  end

  // function starts are one-cycle pulses; busy falls on the done edge
  always_ff @(posedge clk) begin
    if (rst) begin
      fn_start_ff <= '0;
      fn_busy_ff <= '0;
    end else begin
      fn_start_ff <= (wr && hit(adr, rmc_pkg::ADR_FUNC)) ?
        wdata[rmc_pkg::NUM_FN-1:0] : '0;
      // a fresh start beats a stale completion
      fn_busy_ff <= (fn_busy_ff & ~done_rise) | fn_start_ff;
    end
  end

  // parameter bytes, writable only while stopped
  always_ff @(posedge clk) begin
    if (rst) begin
      param_ff <= {rmc_pkg::NUM_PARAM{rmc_pkg::PARAM_RST}};
    end else begin
      for (int i = 0; i < rmc_pkg::NUM_PARAM; i++) begin
        if (wr_ok && hit(adr, rmc_pkg::ADR_PARAM_BASE + 8'(i))) begin
          param_ff[8*i +: 8] <= wdata;
        end
      end
    end
  end

  // event counters; they keep counting in run mode, reads are what is closed
  always_comb begin
    for (int i = 0; i < rmc_pkg::NUM_CNT; i++) begin
      ovf_hit[i] = inc_rise[i] && (cnt_ff[i] == {CNT_W{1'b1}});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < rmc_pkg::NUM_CNT; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < rmc_pkg::NUM_CNT; i++) begin
        if (inc_rise[i]) begin
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  // event classes
  rmc_evt_class #(.W(NUM_PROTO)) u_cls_proto (
    .clk(clk),
    .rst(rst),
    .set(proto_rise),
    .clr((wr && hit(adr, rmc_pkg::ADR_PROTO_EVT)) ? wdata[NUM_PROTO-1:0] : '0),
    .mask_wr(wr && hit(adr, rmc_pkg::ADR_PROTO_MASK)),
    .mask_wdata(wdata[NUM_PROTO-1:0]),
    .latch(proto_latch),
    .mask(proto_mask),
    .pend(cls_pend[rmc_pkg::CLS_PROTO])
  );

  rmc_evt_class #(.W(NCE)) u_cls_cnt (
    .clk(clk),
    .rst(rst),
    .set({ovf_hit, inc_rise}),
    .clr((wr && hit(adr, rmc_pkg::ADR_CNT_EVT)) ? wdata[NCE-1:0] : '0),
    .mask_wr(wr && hit(adr, rmc_pkg::ADR_CNT_MASK)),
    .mask_wdata(wdata[NCE-1:0]),
    .latch(cnt_latch),
    .mask(cnt_mask),
    .pend(cls_pend[rmc_pkg::CLS_CNT])
  );

  rmc_evt_class #(.W(NEE)) u_cls_err (
    .clk(clk),
    .rst(rst),
    .set({err_rise, reject}),
    .clr((wr && hit(adr, rmc_pkg::ADR_ERR_EVT)) ? wdata[NEE-1:0] : '0),
    .mask_wr(wr && hit(adr, rmc_pkg::ADR_ERR_MASK)),
    .mask_wdata(wdata[NEE-1:0]),
    .latch(err_latch),
    .mask(err_mask),
    .pend(cls_pend[rmc_pkg::CLS_ERR])
  );

  // class enables gate the per-class pending summaries
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(cls_pend & intr_mask_ff[rmc_pkg::NUM_CLS-1:0]);
    end
  end

  // read mux; closed or unmapped reads return zero but still answer on time
  always_comb begin
    nxt_rdata = 8'h00;
    if (!reject) begin
      if (hit(adr, rmc_pkg::ADR_MODE)) nxt_rdata = mode_ff;
      if (hit(adr, rmc_pkg::ADR_OPTION)) nxt_rdata = option_ff;
      if (hit(adr, rmc_pkg::ADR_FUNC)) nxt_rdata = 8'(fn_busy_ff | fn_start_ff);
      if (hit(adr, rmc_pkg::ADR_INTR)) nxt_rdata = 8'(cls_pend);
      if (hit(adr, rmc_pkg::ADR_INTR_MASK)) nxt_rdata = intr_mask_ff;
      if (hit(adr, rmc_pkg::ADR_EXC)) nxt_rdata = 8'(acc_state_ff);
      if (hit(adr, rmc_pkg::ADR_PROTO_EVT)) nxt_rdata = 8'(proto_latch);
      if (hit(adr, rmc_pkg::ADR_PROTO_MASK)) nxt_rdata = 8'(proto_mask);
      if (hit(adr, rmc_pkg::ADR_CNT_EVT)) nxt_rdata = 8'(cnt_latch);
      if (hit(adr, rmc_pkg::ADR_CNT_MASK)) nxt_rdata = 8'(cnt_mask);
      if (hit(adr, rmc_pkg::ADR_ERR_EVT)) nxt_rdata = 8'(err_latch);
      if (hit(adr, rmc_pkg::ADR_ERR_MASK)) nxt_rdata = 8'(err_mask);
      if (hit(adr, rmc_pkg::ADR_STAT_CUR)) nxt_rdata = status_sync;
      for (int i = 0; i < rmc_pkg::NUM_CNT; i++) begin
        if (hit(adr, rmc_pkg::ADR_CNT_BASE + 8'(i))) nxt_rdata = 8'(cnt_ff[i]);
      end
      for (int i = 0; i < rmc_pkg::NUM_PARAM; i++) begin
        if (hit(adr, rmc_pkg::ADR_PARAM_BASE + 8'(i))) nxt_rdata = param_ff[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd ? nxt_rdata : 8'h00;
    end
  end

  // outputs to the ring engine never wait on the register port
  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign mode_run = mode_ff[rmc_pkg::MODE_RUN_BIT];
  assign mode_loop = mode_ff[rmc_pkg::MODE_LOOP_LSB +: rmc_pkg::MODE_LOOP_W];
  assign option = option_ff;
  assign fn_start = fn_start_ff;
  assign param = param_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  read_window_a: assert property (
    !rd |=> (rdata == 8'h00)
  ) else $error("read data outside the answer cycle");

  shared_reject_a: assert property (
    (access && is_shared(adr) && mode_run) |=> err_latch[rmc_pkg::ERR_REJECT_BIT]
  ) else $error("closed access not flagged");

  param_lock_a: assert property (
    (wr && hit(adr, rmc_pkg::ADR_PARAM_BASE) && mode_run) |=> $stable(param[7:0])
  ) else $error("parameter written in run mode");

  irq_raise_a: assert property (
    (|(proto_latch & proto_mask) && intr_mask_ff[rmc_pkg::CLS_PROTO]) |=> irq
  ) else $error("interrupt missing");

  irq_gate_a: assert property (
    ((cls_pend & intr_mask_ff[rmc_pkg::NUM_CLS-1:0]) == '0) |=> !irq
  ) else $error("interrupt without enabled condition");

  latch_hold_a: assert property (
    (proto_latch[0] && !(wr && hit(adr, rmc_pkg::ADR_PROTO_EVT))) |=> proto_latch[0]
  ) else $error("event latch lost");

  cnt_event_a: assert property (
    inc_rise[0] |=> (cnt_latch[0] && cnt_ff[0] == $past(cnt_ff[0]) + 1'b1)
  ) else $error("counter increment not reported");

  fn_pulse_a: assert property (
    (wr && hit(adr, rmc_pkg::ADR_FUNC) && wdata[rmc_pkg::FN_CLAIM])
      |=> fn_start[rmc_pkg::FN_CLAIM] ##1 (!fn_start[rmc_pkg::FN_CLAIM]
      && fn_busy_ff[rmc_pkg::FN_CLAIM])
  ) else $error("function start not a single pulse");

  mode_write_a: assert property (
    (wr && hit(adr, rmc_pkg::ADR_MODE)) |=> (mode_run == $past(wdata[rmc_pkg::MODE_RUN_BIT]))
  ) else $error("mode register not written");

  sync_path_a: assert property (
    $rose(proto_evt_in[0]) ##1 proto_evt_in[0] ##1 proto_evt_in[0] |-> ##[0:2] proto_latch[0]
  ) else $error("event did not arrive through synchroniser");
endmodule : rmc_ctrl_port

//--- dv/rmc_host_model.sv
// behavioural host on the byte register port of the control block
`timescale 1ns/10ps
module rmc_host_model (
  input wire logic clk,
  input wire logic slow,
  output logic [7:0] adr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    adr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // a slow host leaves an idle cycle before each access
  task automatic gap();
    if (slow) begin
      @(posedge clk);
    end
  endtask : gap
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    gap();
    @(posedge clk);
    adr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // stale data is not left on the bus
    wdata <= ~d;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    gap();
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // outcome of the last access, fetched right after it
  task automatic rd_exc(output logic [7:0] d);
    rd_reg(rmc_pkg::ADR_EXC, d);
  endtask : rd_exc
endmodule : rmc_host_model

//--- dv/test_ring_mac_control_port.sv
// self-checking bench of the ring mac control port
`timescale 1ns/10ps
module test_ring_mac_control_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [7:0] adr, wdata, rdata, option, r, d;
  logic wr, rd, irq, mode_run;
  logic [7:0] status_in = 8'h00;
  logic [7:0] proto_evt_in = 8'h00;
  logic [2:0] err_in = 3'h0;
  logic [1:0] cnt_inc_in = 2'h0;
  logic [3:0] fn_done_in = 4'h0;
  logic [1:0] mode_loop;
  logic [3:0] fn_start;
  logic [63:0] param;
  logic [63:0] exp_param = 64'h0;
  logic [31:0] seed = 32'd23;
  int miscompares = 0;
  int check_count = 0;
  int k;

  rmc_ctrl_port rmc_ctrl_port_inst (.clk(clk), .rst(rst), .adr(adr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .proto_evt_in(proto_evt_in), .err_in(err_in),
    .cnt_inc_in(cnt_inc_in), .fn_done_in(fn_done_in), .status_in(status_in),
    .irq(irq), .mode_run(mode_run), .mode_loop(mode_loop), .option(option),
    .fn_start(fn_start), .param(param));
  rmc_host_model rmc_host_model_inst (.clk(clk), .slow(slow), .adr(adr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // expected one-hot pattern of event or function bit i
  function automatic logic [7:0] bit_of(input int i);
    return 8'h01 << i;
  endfunction : bit_of
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    rmc_host_model_inst.wr_reg(a, v);
  endtask : wrr
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    rmc_host_model_inst.rd_reg(a, d);
    chk(name, {56'h0, d}, {56'h0, exp});
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait: a hang here ends the run
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 20 && irq !== lvl; n++) cyc(1);
    chk("irq", {63'h0, irq}, {63'h0, lvl});
    if (irq !== lvl) begin
      end_of_test();
    end
  endtask : wait_irq
  // async level must stay put long enough for the two-stage synchroniser
  task automatic pulse_cnt(input int i);
    @(posedge clk) cnt_inc_in[i] <= 1'b1;
    cyc(3);
    @(posedge clk) cnt_inc_in[i] <= 1'b0;
    cyc(3);
  endtask : pulse_cnt

  initial begin
    cyc(10);
    @(posedge clk) rst <= 1'b0;
    cyc(1);
    chk("outs", {48'h0, irq, mode_run, mode_loop, option, fn_start}, 64'h0);
    chk("param", param, 64'h0);
    rchk("exc", rmc_pkg::ADR_EXC, 8'h00);
    rchk("mask", rmc_pkg::ADR_INTR_MASK, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      slow = r[7];
      wrr(rmc_pkg::ADR_OPTION, r);
      chk("option", {56'h0, option}, {56'h0, r});
      rchk("option", rmc_pkg::ADR_OPTION, r);
      wrr(rmc_pkg::ADR_MODE, r & 8'h06);
      chk("loop", {62'h0, mode_loop}, {62'h0, r[2:1]});
      wrr(rmc_pkg::ADR_PARAM_BASE + 8'(i), r);
      exp_param[8*i +: 8] = r;
      rmc_host_model_inst.rd_exc(d);
      chk("exc", {56'h0, d}, 64'h1);
    end
    chk("param", param, exp_param);
    r = rnd();
    @(posedge clk) status_in <= r;
    cyc(4);
    rchk("status", rmc_pkg::ADR_STAT_CUR, r);
    // run mode closes the shared block
    wrr(rmc_pkg::ADR_MODE, 8'h01);
    chk("run", {63'h0, mode_run}, 64'h1);
    wrr(rmc_pkg::ADR_PARAM_BASE, ~exp_param[7:0]);
    rmc_host_model_inst.rd_exc(d);
    chk("exc", {56'h0, d}, 64'h2);
    rchk("shared", rmc_pkg::ADR_STAT_CUR, 8'h00);
    chk("param", param, exp_param);
    rchk("rejlatch", rmc_pkg::ADR_ERR_EVT, 8'h01);
    wrr(rmc_pkg::ADR_ERR_EVT, 8'h01);
    wrr(rmc_pkg::ADR_MODE, 8'h00);
    rchk("rejclr", rmc_pkg::ADR_ERR_EVT, 8'h00);
    // protocol event through both mask levels
    r = rnd();
    k = int'(r[2:0]);
    @(posedge clk) proto_evt_in[k] <= 1'b1;
    cyc(6);
    rchk("latch", rmc_pkg::ADR_PROTO_EVT, bit_of(k));
    chk("irq", {63'h0, irq}, 64'h0);
    wrr(rmc_pkg::ADR_PROTO_MASK, bit_of(k));
    cyc(3);
    chk("irq", {63'h0, irq}, 64'h0);
    wrr(rmc_pkg::ADR_INTR_MASK, 8'h01);
    wait_irq(1'b1);
    rchk("intr", rmc_pkg::ADR_INTR, 8'h01);
    @(posedge clk) proto_evt_in[k] <= 1'b0;
    wrr(rmc_pkg::ADR_PROTO_EVT, bit_of(k));
    wait_irq(1'b0);
    // corner: lowest event bit, the one the synchroniser assertion watches
    @(posedge clk) proto_evt_in[0] <= 1'b1;
    cyc(6);
    rchk("latch0", rmc_pkg::ADR_PROTO_EVT, 8'h01);
    @(posedge clk) proto_evt_in[0] <= 1'b0;
    wrr(rmc_pkg::ADR_PROTO_EVT, 8'h01);
    // counter wraps after 256 increments
    for (int i = 0; i < 256; i++) pulse_cnt(0);
    pulse_cnt(1);
    rchk("cnt0", rmc_pkg::ADR_CNT_BASE, 8'h00);
    rchk("cnt1", rmc_pkg::ADR_CNT_BASE + 8'h01, 8'h01);
    rchk("cntevt", rmc_pkg::ADR_CNT_EVT, 8'h07);
    // asynchronous error reported in error class
    @(posedge clk) err_in[2] <= 1'b1;
    cyc(6);
    rchk("errevt", rmc_pkg::ADR_ERR_EVT, 8'h08);
    wrr(rmc_pkg::ADR_ERR_MASK, 8'h08);
    wrr(rmc_pkg::ADR_INTR_MASK, 8'h04);
    wait_irq(1'b1);
    wrr(rmc_pkg::ADR_ERR_MASK, 8'h00);
    wait_irq(1'b0);
    for (int f = 0; f < rmc_pkg::NUM_FN; f++) begin
      wrr(rmc_pkg::ADR_FUNC, bit_of(f));
      chk("start", {60'h0, fn_start}, {56'h0, bit_of(f)});
      rchk("busy", rmc_pkg::ADR_FUNC, bit_of(f));
      chk("pulse", {60'h0, fn_start}, 64'h0);
      @(posedge clk) fn_done_in[f] <= 1'b1;
      cyc(6);
      rchk("done", rmc_pkg::ADR_FUNC, 8'h00);
      @(posedge clk) fn_done_in[f] <= 1'b0;
    end
    end_of_test();
  end
endmodule : test_ring_mac_control_port
